// *** core/shcd_pkg.sv ***
// package for the serial host command decoder
package shcd_pkg;

  // command classes in the top two bits
  localparam logic [1:0] CLS_READ  = 2'h0;
  localparam logic [1:0] CLS_WRITE = 2'h1;
  localparam logic [1:0] CLS_PAGE  = 2'h2;
  localparam logic [1:0] CLS_INSTR = 2'h3;

  // instruction fields and control codes
  localparam int         INSTR_CAL_BIT = 5;
  localparam logic [4:0] CTL_SW_RESET  = 5'h01;
  localparam logic [4:0] CTL_STANDBY   = 5'h02;
  localparam logic [4:0] CTL_WAKEUP    = 5'h03;
  localparam logic [4:0] CTL_CONV_ONE  = 5'h14;
  localparam logic [4:0] CTL_CONV_CONT = 5'h15;
  localparam logic [4:0] CTL_CONV_HALT = 5'h18;

  // calibration types and channels
  localparam logic [1:0] CAL_DC_OFFSET = 2'h0;
  localparam logic [1:0] CAL_AC_OFFSET = 2'h2;
  localparam logic [1:0] CAL_GAIN      = 2'h3;
  localparam logic [2:0] CH_I1         = 3'h1;
  localparam logic [2:0] CH_V1         = 3'h2;
  localparam logic [2:0] CH_I2         = 3'h3;
  localparam logic [2:0] CH_V2         = 3'h4;
  localparam logic [2:0] CH_ALL        = 3'h6;

  // checksum seed and data length
  localparam logic [7:0] CSUM_SEED   = 8'hff;
  localparam logic [1:0] DATA_LAST   = 2'h2;
  localparam logic [1:0] TX_LAST_RAW = 2'h2;
  localparam logic [1:0] TX_LAST_CS  = 2'h3;
  localparam logic [5:0] PAGE_RESET  = 6'h00;

  // inactivity timeout
  localparam int CLK_HZ      = 40_000_000;
  localparam int TIMEOUT_MS  = 128;
  localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
  localparam int TMO_W       = 23;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_CSUM   = 3'h1,
    ST_DATA   = 3'h3,
    ST_RDWAIT = 3'h2,
    ST_TX     = 3'h6
  } shcd_state_e;

  typedef struct packed {
    logic [11:0] addr;
    logic [23:0] wdata;
  } shcd_req_s;

  typedef struct packed {
    logic       abort;
    logic       sw_reset;
    logic       standby;
    logic       wakeup;
    logic       conv_one;
    logic       conv_cont;
    logic       conv_halt;
    logic       cal_start;
    logic [1:0] cal_type;
    logic [2:0] cal_chan;
  } shcd_instr_s;

endpackage : shcd_pkg

// *** core/shcd_csum.sv ***
// running receive checksum accumulator
`timescale 1ns/1ps
module shcd_csum (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // byte stream
  input  wire logic       clear,
  input  wire logic       add,
  input  wire logic [7:0] data,
  // running sum
  output logic [7:0]      sum
);

  logic [7:0] sum_r;
  logic [7:0] sum_nxt;

  // borrow dropped, so the sum wraps in eight bits
  assign sum_nxt = clear ? shcd_pkg::CSUM_SEED : 8'(sum_r - data);
  assign sum     = sum_r;

  // clear beats add: a closing transaction restarts the seed
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sum_r <= shcd_pkg::CSUM_SEED;
    end else if (clear || add) begin
      sum_r <= sum_nxt;
    end
  end

endmodule : shcd_csum

// *** core/shcd_decoder.sv ***
// serial host command decoder top
`timescale 1ns/1ps
module shcd_decoder #(
  parameter int unsigned TIMEOUT_CYC = shcd_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                 CLK_SYS,
  input  wire logic                 ARST_N,
  // received bytes from the framer
  input  wire logic                 RX_VALID,
  input  wire logic [7:0]           RX_DATA,
  // checksum enable from the serial control register
  input  wire logic                 CSUM_EN,
  // transmitted bytes to the framer
  output logic                      TX_VALID,
  input  wire logic                 TX_READY,
  output logic [7:0]                TX_DATA,
  // register file access
  output logic                      RD_REQ,
  output logic                      WR_REQ,
  output shcd_pkg::shcd_req_s       REG_REQ,
  input  wire logic                 RD_VALID,
  input  wire logic [23:0]          RD_DATA,
  // process control
  output shcd_pkg::shcd_instr_s     INSTR,
  output logic                      CSUM_ERR,
  output logic [5:0]                PAGE
);

  shcd_pkg::shcd_state_e state_r;
  shcd_pkg::shcd_state_e state_nxt;
  logic [7:0]                  cmd_r;
  logic [23:0]                 wdata_r;
  logic [1:0]                  cnt_r;
  logic [5:0]                  page_r;
  logic [31:0]                 tx_sh_r;
  logic [7:0]                  tx_byte_r;
  logic [1:0]                  tx_cnt_r;
  logic                        tx_cs_r;
  logic [shcd_pkg::TMO_W-1:0]  tmo_r;
  logic                        rd_req_r;
  logic                        wr_req_r;
  logic                        csum_err_r;
  shcd_pkg::shcd_req_s         req_r;
  shcd_pkg::shcd_instr_s       instr_r;
  shcd_pkg::shcd_instr_s       instr_nxt;

  logic [7:0]  rx_sum;
  logic        in_rx;
  logic        rx_take;
  logic [7:0]  exec_cmd;
  logic [23:0] exec_wdata;
  logic [1:0]  exec_cls;
  logic        last_data;
  logic        need_cs;
  logic        exec;
  logic        csum_bad;
  logic        rd_go;
  logic        wr_go;
  logic        page_go;
  logic        ins_go;
  logic        tmo_hit;
  logic        tx_take;
  logic        tx_done;
  logic        go_idle;
  logic        is_cal;
  logic [4:0]  ctl_code;
  logic [1:0]  cal_type;
  logic [2:0]  cal_chan;
  logic        cal_ok;
  logic [7:0]  tx_cs;

  ////////////////////////////////////////////////////////////////////////////
  // receive decode

  // bytes are ignored while the answer to a read is pending
  assign in_rx   = (state_r == shcd_pkg::ST_IDLE) ||
                   (state_r == shcd_pkg::ST_DATA) ||
                   (state_r == shcd_pkg::ST_CSUM);
  assign rx_take = RX_VALID && in_rx;

  // the idle byte is always the command
  assign exec_cmd   = (state_r == shcd_pkg::ST_IDLE) ? RX_DATA : cmd_r;
  assign exec_cls   = exec_cmd[7:6];
  assign exec_wdata = (state_r == shcd_pkg::ST_DATA) ?
                      {wdata_r[15:0], RX_DATA} : wdata_r;
  assign last_data  = (state_r == shcd_pkg::ST_DATA) &&
                      (cnt_r == shcd_pkg::DATA_LAST);
  assign need_cs    = CSUM_EN;

  // execute on the final byte, or on a matching checksum byte
  assign csum_bad = rx_take && (state_r == shcd_pkg::ST_CSUM) &&
                    (RX_DATA != rx_sum);
  assign exec = rx_take && (
      ((state_r == shcd_pkg::ST_IDLE) &&
       (RX_DATA[7:6] != shcd_pkg::CLS_WRITE) && !need_cs) ||
      (last_data && !need_cs) ||
      ((state_r == shcd_pkg::ST_CSUM) && (RX_DATA == rx_sum)));

  assign rd_go   = exec && (exec_cls == shcd_pkg::CLS_READ);
  assign wr_go   = exec && (exec_cls == shcd_pkg::CLS_WRITE);
  assign page_go = exec && (exec_cls == shcd_pkg::CLS_PAGE);
  assign ins_go  = exec && (exec_cls == shcd_pkg::CLS_INSTR);

  ////////////////////////////////////////////////////////////////////////////
  // instruction decode

  assign is_cal   = exec_cmd[shcd_pkg::INSTR_CAL_BIT];
  assign ctl_code = exec_cmd[4:0];
  assign cal_type = exec_cmd[4:3];
  assign cal_chan = exec_cmd[2:0];
  // reserved type or channel codes abort but start nothing
  assign cal_ok = (cal_type != 2'h1) &&
                  ((cal_chan == shcd_pkg::CH_I1) ||
                   (cal_chan == shcd_pkg::CH_V1) ||
                   (cal_chan == shcd_pkg::CH_I2) ||
                   (cal_chan == shcd_pkg::CH_V2) ||
                   (cal_chan == shcd_pkg::CH_ALL));

  // every instruction aborts; the code picks what starts next
  always_comb begin
    instr_nxt           = '0;
    instr_nxt.abort     = ins_go;
    instr_nxt.sw_reset  = ins_go && !is_cal &&
                          (ctl_code == shcd_pkg::CTL_SW_RESET);
    instr_nxt.standby   = ins_go && !is_cal &&
                          (ctl_code == shcd_pkg::CTL_STANDBY);
    instr_nxt.wakeup    = ins_go && !is_cal &&
                          (ctl_code == shcd_pkg::CTL_WAKEUP);
    instr_nxt.conv_one  = ins_go && !is_cal &&
                          (ctl_code == shcd_pkg::CTL_CONV_ONE);
    instr_nxt.conv_cont = ins_go && !is_cal &&
                          (ctl_code == shcd_pkg::CTL_CONV_CONT);
    instr_nxt.conv_halt = ins_go && !is_cal &&
                          (ctl_code == shcd_pkg::CTL_CONV_HALT);
    instr_nxt.cal_start = ins_go && is_cal && cal_ok;
    instr_nxt.cal_type  = ins_go ? cal_type : 2'h0;
    instr_nxt.cal_chan  = ins_go ? cal_chan : 3'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // timeout and transmit helpers

  // only a half-received transaction waits on the host
  assign tmo_hit = ((state_r == shcd_pkg::ST_DATA) ||
                    (state_r == shcd_pkg::ST_CSUM)) && !rx_take &&
                   (tmo_r == shcd_pkg::TMO_W'(TIMEOUT_CYC - 1));

  assign tx_take = (state_r == shcd_pkg::ST_TX) && TX_READY;
  assign tx_done = tx_take && (tx_cnt_r == (tx_cs_r ? shcd_pkg::TX_LAST_CS :
                                            shcd_pkg::TX_LAST_RAW));
  assign tx_cs   = 8'(shcd_pkg::CSUM_SEED - RD_DATA[23:16] -
                      RD_DATA[15:8] - RD_DATA[7:0]);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      shcd_pkg::ST_IDLE: begin
        if (rx_take && RX_DATA[7:6] == shcd_pkg::CLS_WRITE) begin
          state_nxt = shcd_pkg::ST_DATA;
        end else if (rx_take && need_cs) begin
          state_nxt = shcd_pkg::ST_CSUM;
        end
      end
      shcd_pkg::ST_DATA: begin
        if (last_data && need_cs) begin
          state_nxt = shcd_pkg::ST_CSUM;
        end else if (last_data) begin
          state_nxt = shcd_pkg::ST_IDLE;
        end
      end
      shcd_pkg::ST_CSUM: begin
        if (rx_take) begin
          state_nxt = shcd_pkg::ST_IDLE;
        end
      end
      shcd_pkg::ST_RDWAIT: begin
        if (RD_VALID) begin
          state_nxt = shcd_pkg::ST_TX;
        end
      end
      shcd_pkg::ST_TX: begin
        if (tx_done) begin
          state_nxt = shcd_pkg::ST_IDLE;
        end
      end
      default: state_nxt = shcd_pkg::ST_IDLE;
    endcase
    if (rd_go) begin
      state_nxt = shcd_pkg::ST_RDWAIT;
    end
    if (tmo_hit) begin
      state_nxt = shcd_pkg::ST_IDLE;
    end
  end

  assign go_idle = (state_nxt == shcd_pkg::ST_IDLE);

  shcd_csum u_rx_csum (
    .clk    (CLK_SYS),
    .arst_n (ARST_N),
    .clear  (go_idle),
    .add    (rx_take && (state_r != shcd_pkg::ST_CSUM)),
    .data   (RX_DATA),
    .sum    (rx_sum)
  );

  // transaction state
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      state_r <= shcd_pkg::ST_IDLE;
      cmd_r   <= 8'h00;
      wdata_r <= 24'h000000;
      cnt_r   <= 2'h0;
      tmo_r   <= '0;
    end else begin
      state_r <= state_nxt;
      if (rx_take && state_r == shcd_pkg::ST_IDLE) begin
        cmd_r <= RX_DATA;
      end
      if (rx_take && state_r == shcd_pkg::ST_DATA) begin
        wdata_r <= exec_wdata;
      end
      // cleared outside DATA so a back-to-back write starts at byte zero
      cnt_r <= (state_r != shcd_pkg::ST_DATA) ? 2'h0 :
               (rx_take ? 2'(cnt_r + 2'h1) : cnt_r);
      tmo_r <= (rx_take || go_idle) ? '0 : shcd_pkg::TMO_W'(tmo_r + 1'b1);
    end
  end

  // page and register requests; page survives everything but a select or a reset
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      page_r     <= shcd_pkg::PAGE_RESET;
      req_r      <= '0;
      rd_req_r   <= 1'b0;
      wr_req_r   <= 1'b0;
      csum_err_r <= 1'b0;
      instr_r    <= '0;
    end else begin
      if (page_go) begin
        page_r <= exec_cmd[5:0];
      end
      if (rd_go || wr_go) begin
        req_r.addr  <= {page_r, exec_cmd[5:0]};
        req_r.wdata <= wr_go ? exec_wdata : 24'h000000;
      end
      rd_req_r   <= rd_go;
      wr_req_r   <= wr_go;
      csum_err_r <= csum_bad;
      instr_r    <= instr_nxt;
    end
  end

  // read answer shifts out high byte first, checksum last
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_sh_r   <= 32'h00000000;
      tx_byte_r <= 8'h00;
      tx_cnt_r  <= 2'h0;
      tx_cs_r   <= 1'b0;
    end else if (state_r == shcd_pkg::ST_RDWAIT && RD_VALID) begin
      tx_sh_r   <= {RD_DATA[15:0], tx_cs, 8'h00};
      tx_byte_r <= RD_DATA[23:16];
      tx_cnt_r  <= 2'h0;
      tx_cs_r   <= CSUM_EN;
    end else if (tx_take) begin
      tx_sh_r   <= {tx_sh_r[23:0], 8'h00};
      tx_byte_r <= tx_sh_r[31:24];
      tx_cnt_r  <= 2'(tx_cnt_r + 2'h1);
    end
  end

  assign TX_VALID = (state_r == shcd_pkg::ST_TX);
  assign TX_DATA  = tx_byte_r;
  assign RD_REQ   = rd_req_r;
  assign WR_REQ   = wr_req_r;
  assign REG_REQ  = req_r;
  assign INSTR    = instr_r;
  assign CSUM_ERR = csum_err_r;
  assign PAGE     = page_r;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  page_load_a: assert property (page_go |=> PAGE == $past(exec_cmd[5:0]))
    else $error("page not stored");
  page_hold_a: assert property ($changed(PAGE) |-> $past(page_go))
    else $error("page changed without select");
  addr_form_a: assert property (rd_go |=>
      RD_REQ && REG_REQ.addr == {$past(page_r), $past(exec_cmd[5:0])})
    else $error("read address wrong");
  write_class_a: assert property (wr_go |=> WR_REQ && !RD_REQ)
    else $error("write not issued");
  read_answer_a: assert property (
      state_r == shcd_pkg::ST_RDWAIT && RD_VALID |=>
      TX_VALID && TX_DATA == $past(RD_DATA[23:16]))
    else $error("read answer wrong");
  instr_abort_a: assert property (ins_go |=> INSTR.abort)
    else $error("instruction did not abort");
  sw_reset_a: assert property (ins_go && exec_cmd[5:0] == 6'h01 |=>
      INSTR.sw_reset && !INSTR.conv_cont)
    else $error("software reset not decoded");
  conv_cont_a: assert property (ins_go && exec_cmd[5:0] == 6'h15 |=>
      INSTR.conv_cont && !INSTR.cal_start)
    else $error("continuous conversion not decoded");
  cal_type_a: assert property (INSTR.cal_start |-> INSTR.cal_type != 2'h1)
    else $error("reserved calibration started");
  csum_drop_a: assert property (csum_bad |=>
      CSUM_ERR && !RD_REQ && !WR_REQ && !INSTR.abort &&
      state_r == shcd_pkg::ST_IDLE)
    else $error("bad checksum not dropped");
  timeout_a: assert property (tmo_hit |=> state_r == shcd_pkg::ST_IDLE)
    else $error("timeout did not reset");

  cov_write_c: cover property (wr_go);
  cov_read_c:  cover property (tx_done);
  cov_cserr_c: cover property (csum_bad);
  cov_cal_c:   cover property (INSTR.cal_start);

endmodule : shcd_decoder

// *** dv/shcd_partner.sv ***
// register file and transmit framer model for the command decoder
`timescale 1ns/1ps
module shcd_partner (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                arst_n,
  // register file requests
  input  wire logic                rd_req,
  input  wire logic                wr_req,
  input  wire shcd_pkg::shcd_req_s req,
  // read return and transmit flow control
  output logic                     rd_valid,
  output logic [23:0]              rd_data,
  output logic                     tx_ready
);
  logic [23:0] mem [0:4095];
  int          seed;
  int          wait_n;
  logic [11:0] rd_addr;
  ////////////////////////////////////////////////////////////////////
  // contents start as an address pattern so reads need no prior write
  initial begin
    seed = 1;
    wait_n = -1;
    rd_addr = 12'h000;
    rd_valid = 1'b0;
    rd_data = 24'h000000;
    tx_ready = 1'b0;
    for (int i = 0; i < 4096; i++) begin
      mem[i] = {12'(i) ^ 12'ha5a, 12'(i)};
    end
  end
  ////////////////////////////////////////////////////////////////////
  // answers slowly or promptly; read data is junk outside the strobe
  always @(posedge clk) begin
    #1;
    tx_ready = ($random(seed) & 3) != 0; // stalls one cycle in four
    rd_valid = 1'b0;
    rd_data = ~rd_data; // no stale value for the decoder to lean on
    if (wr_req && arst_n) begin
      mem[req.addr] = req.wdata;
    end
    if (wait_n == 0) begin
      rd_valid = 1'b1;
      rd_data = mem[rd_addr];
    end
    if (wait_n >= 0) begin
      wait_n--;
    end
    if (rd_req && arst_n) begin
      rd_addr = req.addr;
      wait_n = $random(seed) & 3;
    end
  end
endmodule : shcd_partner

// *** dv/tb.sv ***
// self-checking bench for the serial host command decoder
`timescale 1ns/1ps
module tb;
  logic clk_sys, arst_n, rx_valid, csum_en, tx_valid, tx_ready;
  logic rd_req, wr_req, rd_valid, csum_err;
  logic [7:0]            rx_data, tx_data;
  logic [23:0]           rd_data;
  logic [5:0]            page;
  shcd_pkg::shcd_req_s   reg_req, wr_seen;
  shcd_pkg::shcd_instr_s instr, ins_seen;
  logic [23:0]           shadow [0:4095];
  logic [7:0]            txq [$];
  logic [5:0]            pg;
  int fails, n_compared, n_wr, n_ins, n_err, seed;
  ////////////////////////////////////////////////////////////////////
  // short timeout keeps the idle-gap case cheap
  shcd_decoder #(.TIMEOUT_CYC(20)) u_dut (
    .CLK_SYS(clk_sys), .ARST_N(arst_n), .RX_VALID(rx_valid),
    .RX_DATA(rx_data), .CSUM_EN(csum_en), .TX_VALID(tx_valid),
    .TX_READY(tx_ready), .TX_DATA(tx_data), .RD_REQ(rd_req),
    .WR_REQ(wr_req), .REG_REQ(reg_req), .RD_VALID(rd_valid),
    .RD_DATA(rd_data), .INSTR(instr), .CSUM_ERR(csum_err), .PAGE(page));
  shcd_partner u_partner (
    .clk(clk_sys), .arst_n(arst_n), .rd_req(rd_req), .wr_req(wr_req),
    .req(reg_req), .rd_valid(rd_valid), .rd_data(rd_data),
    .tx_ready(tx_ready));
  always #12.5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////
  // monitor: record every write, instruction and checksum-error pulse and every accepted answer byte
  always @(posedge clk_sys) begin
    if (wr_req === 1'b1) begin n_wr++; wr_seen = reg_req; end
    if (instr.abort === 1'b1) begin n_ins++; ins_seen = instr; end
    if (csum_err === 1'b1) n_err++;
    if (tx_valid === 1'b1 && tx_ready === 1'b1) txq.push_back(tx_data);
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    if (fails == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////
  // expected instruction decode, one-hot per accepted code
  function automatic shcd_pkg::shcd_instr_s exp_instr(input logic [7:0] c);
    shcd_pkg::shcd_instr_s e;
    logic ctl;
    ctl = ~c[5];
    e.abort = 1'b1;
    e.sw_reset = ctl && c[4:0] == 5'h01;
    e.standby = ctl && c[4:0] == 5'h02;
    e.wakeup = ctl && c[4:0] == 5'h03;
    e.conv_one = ctl && c[4:0] == 5'h14;
    e.conv_cont = ctl && c[4:0] == 5'h15;
    e.conv_halt = ctl && c[4:0] == 5'h18;
    e.cal_start = c[5] && c[4:3] != 2'h1 && c[2:0] != 3'h0 &&
                  c[2:0] != 3'h5 && c[2:0] != 3'h7;
    e.cal_type = c[4:3];
    e.cal_chan = c[2:0];
    return e;
  endfunction : exp_instr
  // one byte per cycle, strobe held high across a whole transaction
  task automatic put(input logic [7:0] b, inout logic [7:0] cs);
    @(posedge clk_sys);
    #1;
    rx_valid = 1'b1;
    rx_data = b;
    cs = cs - b;
  endtask : put
  task automatic txn(input logic [7:0] c, input logic [23:0] d,
                     input bit bad);
    logic [7:0] cs;
    cs = 8'hff;
    put(c, cs);
    if (c[7:6] == shcd_pkg::CLS_WRITE) begin
      for (int i = 2; i >= 0; i--) put(d[8*i+:8], cs);
    end
    if (csum_en) put(bad ? ~cs : cs, cs);
    @(posedge clk_sys);
    #1;
    rx_valid = 1'b0;
    rx_data = 8'($random(seed));
    repeat (3) @(posedge clk_sys);
  endtask : txn
  task automatic wr(input logic [5:0] a, input logic [23:0] d,
                    input bit bad);
    int o;
    o = n_wr;
    txn({2'b01, a}, d, bad);
    check(n_wr, o + (bad ? 0 : 1));
    if (!bad) begin
      check(wr_seen, {pg, a, d});
      shadow[{pg, a}] = d;
    end
  endtask : wr
  task automatic rd(input logic [5:0] a);
    logic [23:0] v;
    logic [7:0]  cs;
    int          n;
    txq = {};
    v = shadow[{pg, a}];
    n = csum_en ? 4 : 3;
    txn({2'b00, a}, 24'h000000, 1'b0);
    for (int i = 0; i < 80 && txq.size() < n; i++) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    check(txq.size(), n);
    cs = 8'hff - v[23:16] - v[15:8] - v[7:0];
    for (int i = 0; i < n && i < txq.size(); i++)
      check(txq[i], i < 3 ? v[8*(2-i)+:8] : cs);
  endtask : rd
  task automatic page_sel(input logic [5:0] p);
    txn({2'b10, p}, 24'h000000, 1'b0);
    pg = p;
    check(page, pg);
  endtask : page_sel
  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [7:0] c;
    int         o;
    clk_sys = 1'b0; arst_n = 1'b0; rx_valid = 1'b0; rx_data = 8'h00;
    csum_en = 1'b0; seed = 1; fails = 0; n_compared = 0; pg = 6'h00;
    n_wr = 0; n_ins = 0; n_err = 0;
    for (int i = 0; i < 4096; i++) shadow[i] = {12'(i) ^ 12'ha5a, 12'(i)};
    repeat (20) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    @(posedge clk_sys);
    #1;
    check({tx_valid, rd_req, wr_req, instr, csum_err, page}, 0);
    rd(6'h3f);
    // random page, writes, read-back, page held across all of it
    for (int k = 0; k < 6; k++) begin
      page_sel(6'($random(seed)));
      wr(6'($random(seed)), 24'($random(seed)), 1'b0);
      wr(6'h00, 24'($random(seed)), 1'b0);
      rd(6'($random(seed)));
      rd(6'h00);
      check(page, pg);
    end
    // every control code, then random instructions incl. calibrations
    for (int k = 0; k < 40; k++) begin
      c = k < 6 ? {3'b110, k[0] ? 5'h02 : 5'h03} : {2'b11, 6'($random(seed))};
      if (k < 6) c[4:0] = k == 0 ? 5'h01 : k == 1 ? 5'h02 : k == 2 ? 5'h03 :
                          k == 3 ? 5'h14 : k == 4 ? 5'h15 : 5'h18;
      o = n_ins;
      txn(c, 24'h000000, 1'b0);
      check(n_ins, o + 1);
      check(ins_seen, exp_instr(c));
      check(page, pg);
    end
    // checksum on: good and bad writes, reads with trailing sum
    #1;
    csum_en = 1'b1;
    for (int k = 0; k < 6; k++) begin
      o = n_err;
      wr(6'($random(seed)), 24'($random(seed)), k[0]);
      check(n_err, o + k[0]);
      rd(6'($random(seed)));
    end
    page_sel(6'h2a);
    #1;
    csum_en = 1'b0;
    // back-to-back writes, no idle cycle between the two commands
    o = n_wr;
    put(8'h51, c);
    repeat (3) put(8'h96, c);
    put(8'h52, c);
    repeat (3) put(8'h3c, c);
    @(posedge clk_sys);
    #1;
    rx_valid = 1'b0;
    repeat (3) @(posedge clk_sys);
    check(n_wr, o + 2);
    check(wr_seen, {pg, 6'h12, 24'h3c3c3c});
    shadow[{pg, 6'h11}] = 24'h969696;
    shadow[{pg, 6'h12}] = 24'h3c3c3c;
    rd(6'h11);
    // a stalled write is dropped; the next byte starts a new command
    o = n_wr;
    c = 8'hff;
    put(8'h45, c);
    put(8'h12, c);
    @(posedge clk_sys);
    #1;
    rx_valid = 1'b0;
    repeat (30) @(posedge clk_sys);
    page_sel(6'h15);
    check(n_wr, o);
    rd(6'h05);
    results();
  end
  // watchdog, far beyond the expected run length
  initial begin
    #(25 * 40000);
    fails++;
    results();
  end
endmodule : tb
